// ### bench/address_and_config_register_loading_tb_top.sv
// self-checking bench for the register load block
`timescale 1ns/1ps
module address_and_config_register_loading_tb_top;
   import regload_pkg::*;
   logic            clock, rst_n, word_rx, take_lsb, cyc_in, par_in;
   logic            sw_write, sw_read, hi_slot, req_want, take;
   logic            ld_out, ovf, tint, par_out, par_en, accept;
   logic            apar_out, apar_en, req_out, tiebreak, restart;
   step_fields_type step;
   logic [31:0]     z_bus, sw_wdata, sw_rdata, r;
   logic [23:0]     opa, opb, pa, pexp, ea, eb;
   logic [8:0]      bptr, bexp;
   logic [7:0]      cmd_in, cmd_out, id_reply;
   logic [15:0]     addr_out;
   logic [4:0]      fcode;
   logic [2:0]      tbits;
   logic [1:0]      sw_addr, ld;
   int              n_errors, num_checks;

   step_sequencer_model seq_u (.clock(clock), .step(step), .z_bus(z_bus));
   address_config_loader dut_u (
      .CLOCK(clock), .RST_N(rst_n), .STEP(step), .Z_BUS(z_bus),
      .PROC_WORD_RX(word_rx), .PROC_BYTE_TAKE(take),
      .TAKE_COUNT_LSB(take_lsb), .BUS_FUNC_CODE(fcode),
      .BUS_CYCLE_IN(cyc_in), .BUS_CMD_PARITY_IN(par_in),
      .BUS_CMD_IN(cmd_in), .BUS_CMD_OUT(cmd_out), .BUS_ADDR_OUT(addr_out),
      .HIGH_PRIORITY_SLOT(hi_slot), .REQUEST_WANTED(req_want),
      .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WRITE(sw_write),
      .SW_READ(sw_read), .SW_RDATA(sw_rdata), .OPERAND_ADDR_A(opa),
      .OPERAND_ADDR_B(opb), .PROC_ADDR(pa), .BYTE_POINTER_DBUS(bptr),
      .LOAD_OUTPUT_REG(ld_out), .PROC_ADDR_OVERFLOW_ERROR(ovf),
      .TIMER_INTERRUPT(tint), .CONFIG_TEST_BITS(tbits),
      .ID_REPLY(id_reply), .CMD_PARITY_OUT(par_out),
      .CMD_PARITY_OUT_EN(par_en), .BUS_CYCLE_ACCEPT(accept),
      .ADDR_PARITY_OUT(apar_out), .ADDR_PARITY_EN(apar_en),
      .BUS_REQUEST_OUT(req_out), .REQUEST_TIEBREAK_ENABLE(tiebreak),
      .SELF_TEST_RESTART(restart)
   );

   always #4 clock = ~clock;

   function automatic step_fields_type mk(logic [1:0] l, logic [2:0] pc,
      logic [4:0] fl, logic [5:0] tc, logic [2:0] op, logic cs);
      mk = '{l, pc, fl, tc, op, cs};
   endfunction

   // config bits shown for a given bus-op selection
   function automatic logic [2:0] tsel(logic [7:0] c, logic [2:0] op);
      logic [10:0] w;
      w = {3'h0, c} >> (3 * op[1:0]);
      tsel = w[2:0];
   endfunction

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic sw_wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clock);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_write <= 1'b1;
      @(posedge clock);
      sw_write <= 1'b0;
   endtask

   task automatic sw_rd(input logic [1:0] a, input string n,
                        input logic [31:0] e);
      @(posedge clock);
      sw_addr <= a;
      sw_read <= 1'b1;
      @(posedge clock);
      sw_read <= 1'b0;
      #1 chk(n, e, sw_rdata);
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      end_sim;
   end

   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      {word_rx, take, take_lsb, cyc_in, par_in, sw_write, sw_read, hi_slot,
       req_want, sw_addr, sw_wdata, cmd_in, cmd_out, addr_out, fcode} = '0;
      {ea, eb} = '0;
      void'($urandom(44));
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      // reset state and unmapped address
      sw_rd(SW_CONFIG, "config", CONFIG_RESET);
      sw_rd(SW_TIMER, "timer", TIMER_RESET);
      sw_rd(2'h3, "unmapped", 32'h0);
      // operand loads, every select code then random ones
      for (int i = 0; i < 12; i++) begin
         ld = (i < 4) ? i[1:0] : 2'($urandom);
         r  = $urandom;
         seq_u.run(mk(ld, 0, 0, 0, 0, 0), r);
         ea = (ld == LDSEL_OPA) ? r[23:0] : ea;
         eb = (ld == LDSEL_OPB) ? r[23:0] : eb;
         #1 chk("operand a", ea, opa);
         chk("operand b", eb, opb);
      end
      // procedure address and byte pointer loads
      sw_wr(SW_CONFIG, 32'h10);
      r = $urandom;
      take_lsb <= r[31];
      seq_u.run(mk(0, PLOAD_LOWER, 0, 0, 0, 0), r);
      pexp = r[23:0];
      #1 chk("proc addr", pexp, pa);
      chk("byte pointer", {r[8:1], r[31]}, bptr);
      bexp = r[8:0] + 9'h001;
      @(posedge clock);
      take <= 1'b1;
      @(posedge clock);
      take <= 1'b0;
      #1 chk("byte pointer", {bexp[8:1], r[31]}, bptr);
      sw_wr(SW_CONFIG, 32'h0);
      r = $urandom;
      seq_u.run(mk(0, PLOAD_LOWER, 0, 0, 0, 0), r);
      pexp[8:0] = r[8:0];
      #1 chk("proc addr", pexp, pa);
      r = $urandom;
      seq_u.run(mk(0, PLOAD_UPPER, 0, 0, 0, 0), r);
      pexp[23:9] = r[23:9];
      #1 chk("proc addr", pexp, pa);
      chk("output load", 1, ld_out);
      // increment across the partition boundary, both modes
      for (int u = 0; u < 2; u++) begin
         sw_wr(SW_CONFIG, u ? 32'h10 : 32'h0);
         pexp[8:0] = 9'h1fe;
         seq_u.run(mk(0, PLOAD_LOWER, 0, 0, 0, 0), {8'h0, pexp});
         @(posedge clock);
         word_rx <= 1'b1;
         @(posedge clock);
         word_rx <= 1'b0;
         pexp = u ? pexp + 24'h2 : {pexp[23:9], 9'h000};
         #1 chk("proc increment", pexp, pa);
         chk("page cross", 1, ovf);
      end
      // timer reaching zero, then clear
      sw_wr(SW_CONFIG, 32'h04);
      seq_u.run(mk(0, 0, FL_TIMER_LOAD, 0, 0, 0), 32'h00fffffd);
      repeat (2) @(posedge clock);
      #1 chk("interrupt", 0, tint);
      @(posedge clock);
      #1 chk("interrupt", 1, tint);
      sw_rd(SW_STATUS, "status", 32'h1);
      seq_u.run(mk(0, 0, 0, TC_TIMER_CLEAR, 0, 0), 32'h0);
      #1 chk("interrupt", 0, tint);
      // timer held while disabled
      sw_wr(SW_CONFIG, 32'h0);
      for (int k = 0; k < 2; k++) begin
         r = k ? $urandom : 32'h00ffffff;
         seq_u.run(mk(0, 0, FL_TIMER_LOAD, 0, 0, 0), r);
         repeat (3) @(posedge clock);
         #1 chk("interrupt", 0, tint);
         sw_rd(SW_TIMER, "timer", {8'h0, r[23:0]});
      end
      // firmware config load touches only its two bits
      sw_wr(SW_CONFIG, 32'hfc);
      seq_u.run(mk(0, 0, 0, 0, 0, 1'b1), ~32'h2);
      sw_rd(SW_CONFIG, "config", 32'hfd);
      // command parity good and bad, address parity generated
      for (int k = 0; k < 8; k++) begin
         r = $urandom;
         @(posedge clock);
         {cmd_in, cmd_out} <= r[15:0];
         addr_out <= r[31:16];
         par_in <= ^r[15:8] ^ k[0];
         cyc_in <= 1'b1;
         {hi_slot, req_want} <= r[17:16];
         #1 chk("accept", !k[0], accept);
         chk("cmd parity", ^r[7:0], par_out);
         chk("addr parity", ^r[31:16], apar_out);
         chk("parity enables", 2'b11, {par_en, apar_en});
         chk("request", req_want, req_out);
         chk("tiebreak", 0, tiebreak);
      end
      @(posedge clock);
      cyc_in <= 1'b0;
      seq_u.run(mk(0, 0, 0, 0, 0, 1'b1), 32'h2);
      sw_rd(SW_CONFIG, "config", 32'hfe);
      // test selection and identification reply
      for (int op = 0; op < 8; op++) begin
         seq_u.present(mk(0, 0, 0, 0, op[2:0], 0), 32'h0);
         fcode <= op[0] ? FC_WHO_ARE_YOU : 5'h0;
         #1 chk("test bits", tsel(8'hfe, op[2:0]), tbits);
         chk("id reply", op[0] ? tsel(8'hfe, op[2:0]) : 0, id_reply);
      end
      // remote reinitialise cycle
      @(posedge clock);
      fcode  <= FC_REINIT;
      cyc_in <= 1'b1;
      par_in <= ^cmd_in;
      @(posedge clock);
      cyc_in <= 1'b0;
      #1 chk("restart", 1, restart);
      end_sim;
   end
endmodule

// ### bench/step_sequencer_model.sv
// firmware step sequencer model driving step fields and z-bus
`timescale 1ns/1ps
module step_sequencer_model
   import regload_pkg::*;
(
   // clock
   input  wire logic        clock,
   // step outputs
   output step_fields_type  step,
   output logic      [31:0] z_bus
);
   initial begin
      step  = '0;
      z_bus = 32'h0;
   end

   // present a step's fields and hold them
   task automatic present(input step_fields_type f, input logic [31:0] z);
      @(posedge clock);
      step  <= f;
      z_bus <= z;
   endtask

   // one firmware step per clock, then idle fields and a changed bus
   task automatic run(input step_fields_type f, input logic [31:0] z);
      present(f, z);
      @(posedge clock);
      step  <= '0;
      z_bus <= ~z;
   endtask
endmodule

// ### src/address_config_loader.sv
// operand, procedure address, timer and configuration load logic
//
// Summary of operation
// R1: load-select 01 loads operand register a
// R2: load-select 11 loads operand register b
// R3: operand registers 24 bits from z-bus only
// R4: unpartitioned code one loads all bits
// R5: partitioned code one loads low nine bits
// R6: code five loads upper fifteen and output
// R7: procedure address advances two per word
// R8: byte pointer mirrors procedure address loads
// R9: pointer counts bytes, take bit is units
// R10: flag-load 05 loads accounting timer
// R11: timer increments once per firmware step
// R12: timer zero interrupts, condition 25 clears
// R13: timer counts only while enabled
// R14: eight config bits, two firmware loadable
// R15: config load takes z-bus bits 3, 1
// R16: master clear initialises config outputs
// R17: bus-op field selects tested config bits
// R18: page select picks 512 or 8192 boundary
// R19: unpartitioned carry crosses partition boundary
// R20: command parity generated, checked, bad ignored
// R21: test bits form identification reply low bits
// R22: steal bit makes request low priority
// R23: reinit enable restarts self test on 01
// R24: address parity covers low sixteen bits
// R25: each firmware step is one clock
`timescale 1ns/1ps
module address_config_loader
   import regload_pkg::*;
(
   // clock and reset
   input  wire logic            CLOCK,
   input  wire logic            RST_N,
   // firmware step fields and data
   input  wire step_fields_type STEP,
   input  wire logic [31:0]     Z_BUS,
   input  wire logic            PROC_WORD_RX,
   input  wire logic            PROC_BYTE_TAKE,
   input  wire logic            TAKE_COUNT_LSB,
   // bus side
   input  wire logic [4:0]      BUS_FUNC_CODE,
   input  wire logic            BUS_CYCLE_IN,
   input  wire logic            BUS_CMD_PARITY_IN,
   input  wire logic [7:0]      BUS_CMD_IN,
   input  wire logic [7:0]      BUS_CMD_OUT,
   input  wire logic [15:0]     BUS_ADDR_OUT,
   input  wire logic            HIGH_PRIORITY_SLOT,
   input  wire logic            REQUEST_WANTED,
   // software register port
   input  wire logic [1:0]      SW_ADDR,
   input  wire logic [31:0]     SW_WDATA,
   input  wire logic            SW_WRITE,
   input  wire logic            SW_READ,
   output logic      [31:0]     SW_RDATA,
   // register outputs
   output logic      [23:0]     OPERAND_ADDR_A,
   output logic      [23:0]     OPERAND_ADDR_B,
   output logic      [23:0]     PROC_ADDR,
   output logic      [8:0]      BYTE_POINTER_DBUS,
   output logic                 LOAD_OUTPUT_REG,
   output logic                 PROC_ADDR_OVERFLOW_ERROR,
   output logic                 TIMER_INTERRUPT,
   output logic      [2:0]      CONFIG_TEST_BITS,
   output logic      [7:0]      ID_REPLY,
   // bus control outputs
   output logic                 CMD_PARITY_OUT,
   output logic                 CMD_PARITY_OUT_EN,
   output logic                 BUS_CYCLE_ACCEPT,
   output logic                 ADDR_PARITY_OUT,
   output logic                 ADDR_PARITY_EN,
   output logic                 BUS_REQUEST_OUT,
   output logic                 REQUEST_TIEBREAK_ENABLE,
   output logic                 SELF_TEST_RESTART
);
   logic [23:0] opa_reg;
   logic [23:0] opb_reg;
   logic [23:0] padr_reg;
   logic [23:0] padr_next;
   logic [8:0]  bptr_reg;
   logic [8:0]  bptr_next;
   logic [23:0] timer_reg;
   logic [23:0] timer_next;
   logic        tint_reg;
   logic        ovf_reg;
   logic        outr_reg;
   logic        restart_reg;
   logic [31:0] rdata_reg;
   logic [7:0]  config_bits;
   logic [2:0]  test_bits;

   // decode
   wire logic unpart     = config_bits[CFG_UNPART];
   wire logic load_a     = STEP.load_select_field == LDSEL_OPA; // R1
   wire logic load_b     = STEP.load_select_field == LDSEL_OPB; // R2
   wire logic code_one   = STEP.proc_load_code == PLOAD_LOWER;
   wire logic lower_stb  = code_one; // R5
   wire logic upper_stb  = (code_one && unpart) ||
                           STEP.proc_load_code == PLOAD_UPPER; // R4 R6
   wire logic timer_load = STEP.flag_load_field == FL_TIMER_LOAD; // R10
   wire logic timer_en   = config_bits[CFG_TIMER_EN];
   wire logic timer_clr  = STEP.test_condition == TC_TIMER_CLEAR;
   wire logic sw_cfg_wr  = SW_WRITE && SW_ADDR == SW_CONFIG;
   wire logic sw_tmr_wr  = SW_WRITE && SW_ADDR == SW_TIMER;
   wire logic cmd_par_en = config_bits[CFG_CMD_PARITY];
   wire logic cmd_par_ok = ^{BUS_CMD_IN, BUS_CMD_PARITY_IN} == 1'b0;
   wire logic page_bit   = config_bits[CFG_PAGE_SEL] ?
                           padr_reg[PAGE_BIT_8192] : padr_reg[PAGE_BIT_512];
   wire logic page_bit_n = config_bits[CFG_PAGE_SEL] ?
                           padr_next[PAGE_BIT_8192] :
                           padr_next[PAGE_BIT_512]; // R18
   wire logic [8:0]  low_inc = padr_reg[8:0] + 9'h002; // R7
   wire logic        low_cy  = padr_reg[8:0] > 9'h1fd;
   wire logic [14:0] up_inc  = padr_reg[23:9] + {14'h0000, low_cy};

   // procedure address and byte pointer next values
   always_comb begin
      padr_next = padr_reg;
      bptr_next = bptr_reg;
      if (PROC_WORD_RX) begin
         padr_next[8:0] = low_inc; // R7
         if (unpart) begin
            padr_next[23:9] = up_inc; // R19
         end
      end
      if (PROC_BYTE_TAKE) begin
         bptr_next = bptr_reg + 9'h001; // R9
      end
      if (lower_stb) begin
         padr_next[8:0] = Z_BUS[8:0]; // R5
         bptr_next      = Z_BUS[8:0]; // R8
      end
      if (upper_stb) begin
         padr_next[23:9] = Z_BUS[23:9]; // R4 R6
      end
   end

   // accounting timer
   always_comb begin
      timer_next = timer_reg;
      if (timer_en) begin
         timer_next = timer_reg + 24'h000001; // R11 R13
      end
      if (timer_load) begin
         timer_next = Z_BUS[23:0]; // R10
      end else if (sw_tmr_wr) begin
         timer_next = SW_WDATA[23:0];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         opa_reg <= 24'h000000;
         opb_reg <= 24'h000000;
      end else begin
         if (load_a) begin
            opa_reg <= Z_BUS[23:0]; // R1 R3
         end
         if (load_b) begin
            opb_reg <= Z_BUS[23:0]; // R2 R3
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         padr_reg <= 24'h000000;
         bptr_reg <= 9'h000;
         ovf_reg  <= 1'b0;
         outr_reg <= 1'b0;
      end else begin
         padr_reg <= padr_next; // R25
         bptr_reg <= bptr_next;
         ovf_reg  <= PROC_WORD_RX && page_bit != page_bit_n; // R18
         outr_reg <= STEP.proc_load_code == PLOAD_UPPER; // R6
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         timer_reg <= TIMER_RESET;
         tint_reg  <= 1'b0;
      end else begin
         timer_reg <= timer_next; // R25
         // a fresh zero wins over a same-step clear
         if (timer_en && timer_next == 24'h000000 && !timer_load) begin
            tint_reg <= 1'b1; // R12
         end else if (timer_clr) begin
            tint_reg <= 1'b0; // R12
         end
      end
   end

   // bus side reinitialise detection
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= config_bits[CFG_REINIT] && BUS_CYCLE_ACCEPT &&
                        BUS_FUNC_CODE == FC_REINIT; // R23
      end
   end

   // software read port
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_reg <= 32'h00000000;
      end else if (SW_READ) begin
         unique case (SW_ADDR)
            SW_CONFIG: rdata_reg <= {24'h000000, config_bits};
            SW_TIMER:  rdata_reg <= {8'h00, timer_reg};
            SW_STATUS: rdata_reg <= {29'h00000000, restart_reg, ovf_reg,
                                     tint_reg};
            default:   rdata_reg <= 32'h00000000;
         endcase
      end else begin
         rdata_reg <= 32'h00000000;
      end
   end

   config_control u_config (
      .clock              (CLOCK),
      .rst_n              (RST_N),
      .config_load_strobe (STEP.config_load_strobe),
      .z_bus              (Z_BUS),
      .sw_write           (sw_cfg_wr),
      .sw_data            (SW_WDATA[7:0]),
      .bus_op_field       (STEP.bus_op_field),
      .config_bits        (config_bits),
      .config_test_bits   (test_bits)
   ); // R14 R16 R17

   assign SW_RDATA                 = rdata_reg;
   assign OPERAND_ADDR_A           = opa_reg;
   assign OPERAND_ADDR_B           = opb_reg;
   assign PROC_ADDR                = padr_reg;
   assign BYTE_POINTER_DBUS        = {bptr_reg[8:1], TAKE_COUNT_LSB}; // R9
   assign LOAD_OUTPUT_REG          = outr_reg;
   assign PROC_ADDR_OVERFLOW_ERROR = ovf_reg;
   assign TIMER_INTERRUPT          = tint_reg;
   assign CONFIG_TEST_BITS         = test_bits;
   assign ID_REPLY = BUS_FUNC_CODE == FC_WHO_ARE_YOU ?
                     {5'h00, test_bits} : 8'h00; // R21
   assign CMD_PARITY_OUT           = ^BUS_CMD_OUT; // R20
   assign CMD_PARITY_OUT_EN        = cmd_par_en; // R20
   assign BUS_CYCLE_ACCEPT = BUS_CYCLE_IN &&
                             (!cmd_par_en || cmd_par_ok); // R20
   assign ADDR_PARITY_OUT          = ^BUS_ADDR_OUT; // R24
   assign ADDR_PARITY_EN           = config_bits[CFG_ADDR_PAR]; // R24
   assign BUS_REQUEST_OUT          = REQUEST_WANTED;
   assign REQUEST_TIEBREAK_ENABLE  = REQUEST_WANTED && HIGH_PRIORITY_SLOT &&
                                     !config_bits[CFG_STEAL]; // R22
   assign SELF_TEST_RESTART        = restart_reg;

   a_opa_load_z: assert property (@(posedge CLOCK) disable iff (!RST_N) // R1
      load_a |=> OPERAND_ADDR_A == $past(Z_BUS[23:0]))
      else $error("operand a not loaded");
   a_opb_hold_val: assert property (@(posedge CLOCK) disable iff (!RST_N) // R2
      !load_b |=> $stable(OPERAND_ADDR_B))
      else $error("operand b changed without load");
   a_lower_only: assert property (@(posedge CLOCK) disable iff (!RST_N) // R5
      code_one && !unpart && !PROC_WORD_RX |=>
         PROC_ADDR[23:9] == $past(padr_reg[23:9]) &&
         PROC_ADDR[8:0] == $past(Z_BUS[8:0]))
      else $error("partitioned lower load wrong");
   a_upper_load: assert property (@(posedge CLOCK) disable iff (!RST_N) // R6
      STEP.proc_load_code == PLOAD_UPPER |=>
         PROC_ADDR[23:9] == $past(Z_BUS[23:9]) && LOAD_OUTPUT_REG)
      else $error("upper load wrong");
   a_word_adv_two: assert property (@(posedge CLOCK) disable iff (!RST_N) // R7
      PROC_WORD_RX && !lower_stb && !upper_stb |=>
         PROC_ADDR[8:0] == $past(padr_reg[8:0]) + 9'h002)
      else $error("procedure address did not advance by two");
   a_timer_load_z: assert property (@(posedge CLOCK) disable iff (!RST_N) // R10
      timer_load |=> timer_reg == $past(Z_BUS[23:0]))
      else $error("timer not loaded");
   a_timer_count: assert property (@(posedge CLOCK) disable iff (!RST_N) // R13
      !timer_en && !timer_load && !sw_tmr_wr |=> $stable(timer_reg))
      else $error("timer counted while disabled");
   a_tint_clear: assert property (@(posedge CLOCK) disable iff (!RST_N) // R12
      timer_clr && !(timer_en && timer_next == 24'h000000) |=>
         !TIMER_INTERRUPT)
      else $error("interrupt not cleared");
   a_cmd_par_drop: assert property (@(posedge CLOCK) disable iff (!RST_N) // R20
      cmd_par_en && !cmd_par_ok |-> !BUS_CYCLE_ACCEPT)
      else $error("bad command parity accepted");
   a_opa_hold: assert property (@(posedge CLOCK) disable iff (!RST_N) // R1
      !load_a |=>
         $stable(OPERAND_ADDR_A))
      else $error("operand a changed without load");
   a_opb_load: assert property (@(posedge CLOCK) disable iff (!RST_N) // R2
      load_b |=>
         OPERAND_ADDR_B == $past(Z_BUS[23:0]))
      else $error("operand b not loaded");
   a_full_load: assert property (@(posedge CLOCK) disable iff (!RST_N) // R4
      code_one && unpart |=>
         PROC_ADDR == $past(Z_BUS[23:0]))
      else $error("unpartitioned load did not take all bits");
   a_bptr_load: assert property (@(posedge CLOCK) disable iff (!RST_N) // R8
      lower_stb |=>
         bptr_reg == $past(Z_BUS[8:0]))
      else $error("byte pointer not loaded with address");
   a_bptr_take: assert property (@(posedge CLOCK) disable iff (!RST_N) // R9
      PROC_BYTE_TAKE && !lower_stb |=>
         bptr_reg == $past(bptr_reg) + 9'h001)
      else $error("byte pointer did not count a taken byte");
   a_timer_step: assert property (@(posedge CLOCK) disable iff (!RST_N) // R11
      timer_en && !timer_load && !sw_tmr_wr |=>
         timer_reg == $past(timer_reg) + 24'h000001)
      else $error("timer did not count one step");
   a_tint_set: assert property (@(posedge CLOCK) disable iff (!RST_N) // R12
      timer_en && !timer_load && !sw_tmr_wr &&
         timer_reg == 24'hffffff |=> TIMER_INTERRUPT)
      else $error("interrupt not raised at zero");
   a_tint_hold: assert property (@(posedge CLOCK) disable iff (!RST_N) // R12
      TIMER_INTERRUPT && !timer_clr |=>
         TIMER_INTERRUPT)
      else $error("interrupt dropped without clear");
   a_outr_idle: assert property (@(posedge CLOCK) disable iff (!RST_N) // R6
      STEP.proc_load_code != PLOAD_UPPER |=>
         !LOAD_OUTPUT_REG)
      else $error("output register load without code five");
   a_part_carry: assert property (@(posedge CLOCK) disable iff (!RST_N) // R19
      PROC_WORD_RX && !unpart && !upper_stb |=>
         PROC_ADDR[23:9] == $past(padr_reg[23:9]))
      else $error("carry crossed partition boundary");
   a_long_carry: assert property (@(posedge CLOCK) disable iff (!RST_N) // R19
      PROC_WORD_RX && unpart && !lower_stb && !upper_stb |=>
         PROC_ADDR == $past(padr_reg) + 24'h000002)
      else $error("unpartitioned increment wrong");
   a_page_cross: assert property (@(posedge CLOCK) disable iff (!RST_N) // R18
      PROC_WORD_RX && !lower_stb && !upper_stb &&
         !config_bits[CFG_PAGE_SEL] && &padr_reg[7:1] |=>
         PROC_ADDR_OVERFLOW_ERROR)
      else $error("page crossing not flagged");
   a_steal_low: assert property (@(posedge CLOCK) disable iff (!RST_N) // R22
      config_bits[CFG_STEAL] |->
         !REQUEST_TIEBREAK_ENABLE)
      else $error("tiebreak raised while stealing");
   a_reinit_off: assert property (@(posedge CLOCK) disable iff (!RST_N) // R23
      !config_bits[CFG_REINIT] |=>
         !SELF_TEST_RESTART)
      else $error("self test restarted while disabled");
   a_id_reply: assert property (@(posedge CLOCK) disable iff (!RST_N) // R21
      BUS_FUNC_CODE == FC_WHO_ARE_YOU |->
         ID_REPLY == {5'h00, CONFIG_TEST_BITS})
      else $error("identification reply wrong");
   a_par_off_ok: assert property (@(posedge CLOCK) disable iff (!RST_N) // R20
      !cmd_par_en && BUS_CYCLE_IN |->
         BUS_CYCLE_ACCEPT)
      else $error("cycle refused with parity disabled");
endmodule

// ### src/config_control.sv
// eight-bit configuration register with firmware load and test select
`timescale 1ns/1ps
module config_control
   import regload_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // loads
   input  wire logic        config_load_strobe,
   input  wire logic [31:0] z_bus,
   input  wire logic        sw_write,
   input  wire logic [7:0]  sw_data,
   input  wire logic [2:0]  bus_op_field,
   // outputs
   output logic      [7:0]  config_bits,
   output logic      [2:0]  config_test_bits
);
   logic [7:0] config_reg;
   logic [7:0] config_next;
   logic [7:0] sel_word;

   // firmware alters only two bits; software may preset all
   always_comb begin
      config_next = config_reg;
      if (sw_write) begin
         config_next = sw_data;
      end
      if (config_load_strobe) begin
         config_next[CFG_CMD_PARITY] = z_bus[ZB_CMD_PARITY]; // R15
         config_next[CFG_REINIT]     = z_bus[ZB_REINIT];     // R15
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         config_reg <= CONFIG_RESET; // R16
      end else begin
         config_reg <= config_next;
      end
   end

   assign config_bits = config_reg;
   // bus op field picks the group shown on the test conditions
   assign sel_word = config_reg >> {bus_op_field[1:0], 1'b0} >> bus_op_field[1:0];
   assign config_test_bits = sel_word[2:0]; // R17

   a_cfg_load_bits: assert property (@(posedge clock) disable iff (!rst_n) // R15
      config_load_strobe |=> config_reg[CFG_CMD_PARITY] ==
         $past(z_bus[ZB_CMD_PARITY]) && config_reg[CFG_REINIT] ==
         $past(z_bus[ZB_REINIT]))
      else $error("config load did not take z bus bits");
endmodule

// ### src/regload_pkg.sv
// shared constants and types for the register load block
package regload_pkg;
   localparam int         ADDR_W          = 24;
   localparam int         LOWER_W         = 9;
   localparam int         UPPER_W         = 15;
   localparam logic [1:0] LDSEL_OPA       = 2'h1;
   localparam logic [1:0] LDSEL_OPB       = 2'h3;
   localparam logic [2:0] PLOAD_LOWER     = 3'h1;
   localparam logic [2:0] PLOAD_UPPER     = 3'h5;
   localparam logic [4:0] FL_TIMER_LOAD   = 5'h05;
   localparam logic [5:0] TC_TIMER_CLEAR  = 6'h19;
   localparam logic [4:0] FC_WHO_ARE_YOU  = 5'h1a;
   localparam logic [4:0] FC_REINIT       = 5'h01;
   localparam int         ZB_CMD_PARITY   = 3;
   localparam int         ZB_REINIT       = 1;
   localparam int         PAGE_BIT_512    = 8;
   localparam int         PAGE_BIT_8192   = 12;
   localparam logic [7:0] CONFIG_RESET    = 8'h00;
   localparam logic [23:0] TIMER_RESET    = 24'h000000;
   localparam int         CFG_CMD_PARITY  = 0;
   localparam int         CFG_REINIT      = 1;
   localparam int         CFG_TIMER_EN    = 2;
   localparam int         CFG_PAGE_SEL    = 3;
   localparam int         CFG_UNPART      = 4;
   localparam int         CFG_STEAL       = 5;
   localparam int         CFG_ADDR_PAR    = 6;
   localparam int         CFG_SPARE       = 7;
   localparam logic [1:0] SW_CONFIG       = 2'h0;
   localparam logic [1:0] SW_TIMER        = 2'h1;
   localparam logic [1:0] SW_STATUS       = 2'h2;

   typedef struct packed {
      logic [1:0] load_select_field;
      logic [2:0] proc_load_code;
      logic [4:0] flag_load_field;
      logic [5:0] test_condition;
      logic [2:0] bus_op_field;
      logic       config_load_strobe;
   } step_fields_type;
endpackage
